/* rtl/ccr_pkg.sv */
// constants and carriers for the core control and interrupt control one registers
// assumes a plain register port with read data one cycle after the read strobe
package ccr_pkg;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  ccr_addr_core_control  = 4'h0;
	localparam logic [3:0]  ccr_addr_intcon_one    = 4'h1;
	localparam logic [3:0]  ccr_addr_status        = 4'h2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          ccr_bit_var_latency    = 15;
	localparam int          ccr_bit_prio_flag      = 3;
	localparam int          ccr_bit_nest_disable   = 15;
	localparam int          ccr_lsb_lower_prio     = 5;
	localparam int          ccr_bit_core_unused    = 14;
	localparam int          ccr_bit_intcon_unused  = 0;

	// ----------------------------------------------------------------
	// reset values and masks
	// ----------------------------------------------------------------
	localparam logic [15:0] ccr_core_reset         = 16'h0020;
	localparam logic [15:0] ccr_intcon_reset       = 16'h0000;
	localparam logic [15:0] ccr_status_reset       = 16'h0000;
	// software-writable bits; bit 14, the depth field, the flag and bit 2 are out
	localparam logic [15:0] ccr_core_wmask         = 16'hb8f3;
	// bit 0 unimplemented
	localparam logic [15:0] ccr_intcon_wmask       = 16'hfffe;
	localparam logic [2:0]  ccr_prio_seven         = 3'h7;

	typedef struct packed
	{
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ccr_req_type;

endpackage : ccr_pkg

/* rtl/ccr_regs.sv */
// core control and interrupt control one registers with priority level
// assumes all inputs are on core_clk; cpu_prio_level is driven by the cpu core
//
// Functional notes
// - top core bit selects variable latency
// - flag set when priority exceeds seven
// - level is flag above lower bits
// - unimplemented bits read as zero
// - reset all zero, saturation enable one
// - flag set disables user interrupts
// - nesting disable locks lower priority bits
//
// The implementer's own choices: the address-and-strobe port and the address map.
module ccr_regs
	import ccr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire ccr_req_type bus_req,
	output logic [15:0]      rdata,
	input  wire logic [3:0]  cpu_prio_level,
	output logic             var_latency,
	output logic [3:0]       cpu_priority,
	output logic             user_int_disable,
	output logic             lower_prio_lock
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [15:0] core_control_reg;
	logic [15:0] core_control_next;
	logic [15:0] intcon_one_reg;
	logic [15:0] intcon_one_next;
	logic [2:0]  lower_prio_reg;
	logic [2:0]  lower_prio_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic        var_reg;
	logic        var_next;
	logic [3:0]  prio_reg;
	logic [3:0]  prio_next;
	logic        uid_reg;
	logic        uid_next;
	logic        lock_reg;
	logic        lock_next;
	logic        flag;

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	// one address compare shared by the write and read decoders
	function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
		hit = (a == b);
	endfunction

	// write strobe aimed at one register index
	function automatic logic wr_hit(input ccr_req_type req, input logic [3:0] idx);
		wr_hit = req.wr && hit(req.addr, idx);
	endfunction

	// bits inside the mask come from the bus, the rest keep their value
	function automatic logic [15:0] merge(
		input logic [15:0] old_value,
		input logic [15:0] new_value,
		input logic [15:0] mask
	);
		merge = (new_value & mask) | (old_value & ~mask);
	endfunction

	// ----------------------------------------------------------------
	// priority flag
	// ----------------------------------------------------------------
	// flag from priority
	always_comb
	begin
		flag = (cpu_prio_level > {1'b0, ccr_prio_seven});
	end

	// ----------------------------------------------------------------
	// core control register
	// ----------------------------------------------------------------
	always_comb
	begin
		core_control_next = core_control_reg;
		if (wr_hit(bus_req, ccr_addr_core_control))
		begin
			core_control_next = merge(core_control_reg, bus_req.wdata, ccr_core_wmask);
		end
		// hardware owns the flag
		// the flag follows the core on every cycle with clk_en high, so software can never mask a trap level
		core_control_next[ccr_bit_prio_flag] = flag;
		core_control_next[ccr_bit_core_unused] = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			core_control_reg <= ccr_core_reset;
		end
		else if (clk_en)
		begin
			core_control_reg <= core_control_next;
		end
	end

	// ----------------------------------------------------------------
	// interrupt control register one
	// ----------------------------------------------------------------
	always_comb
	begin
		intcon_one_next = intcon_one_reg;
		if (wr_hit(bus_req, ccr_addr_intcon_one))
		begin
			intcon_one_next = merge(intcon_one_reg, bus_req.wdata, ccr_intcon_wmask);
		end
		intcon_one_next[ccr_bit_intcon_unused] = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			intcon_one_reg <= ccr_intcon_reset;
		end
		else if (clk_en)
		begin
			intcon_one_reg <= intcon_one_next;
		end
	end

	// ----------------------------------------------------------------
	// lower priority bits
	// ----------------------------------------------------------------
	always_comb
	begin
		lower_prio_next = lower_prio_reg;
		// lock while nesting disabled
		// the lock is the stored bit, so a write that sets it bites from the next cycle
		if (wr_hit(bus_req, ccr_addr_status) && !intcon_one_reg[ccr_bit_nest_disable])
		begin
			lower_prio_next = bus_req.wdata[ccr_lsb_lower_prio +: 3];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			lower_prio_reg <= ccr_status_reset[ccr_lsb_lower_prio +: 3];
		end
		else if (clk_en)
		begin
			lower_prio_reg <= lower_prio_next;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// zero outside the answer cycle while clk_en is high; with clk_en low rdata holds the last word, answer or not
	always_comb
	begin
		rdata_next = 16'h0000;
		if (bus_req.rd)
		begin
			case (1'b1)
				hit(bus_req.addr, ccr_addr_core_control):
				begin
					rdata_next = core_control_reg;
				end
				hit(bus_req.addr, ccr_addr_intcon_one):
				begin
					rdata_next = intcon_one_reg;
				end
				hit(bus_req.addr, ccr_addr_status):
				begin
					rdata_next[ccr_lsb_lower_prio +: 3] = lower_prio_reg;
				end
				default:
				begin
					rdata_next = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			rdata_reg <= 16'h0000;
		end
		else if (clk_en)
		begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	// flops give the core clean levels at the cost of one cycle behind the registers
	always_comb
	begin
		var_next  = core_control_reg[ccr_bit_var_latency];
		prio_next = {core_control_reg[ccr_bit_prio_flag], lower_prio_reg};
		uid_next  = core_control_reg[ccr_bit_prio_flag];
		lock_next = intcon_one_reg[ccr_bit_nest_disable];
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			var_reg  <= 1'b0;
			prio_reg <= 4'h0;
			uid_reg  <= 1'b0;
			lock_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			var_reg  <= var_next;
			prio_reg <= prio_next;
			uid_reg  <= uid_next;
			lock_reg <= lock_next;
		end
	end

	assign rdata            = rdata_reg;
	assign var_latency      = var_reg;
	assign cpu_priority     = prio_reg;
	assign user_int_disable = uid_reg;
	assign lower_prio_lock  = lock_reg;

endmodule // ccr_regs

/* tb/ccr_regs_props.sv */
// port checker for ccr_regs, bound below
// assumes one core_clk domain
module ccr_regs_chk
	import ccr_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        clk_en,
	input wire ccr_req_type bus_req,
	input wire logic [15:0] rdata,
	input wire logic [3:0]  cpu_prio_level,
	input wire logic [3:0]  cpu_priority,
	input wire logic        var_latency,
	input wire logic        user_int_disable,
	input wire logic        lower_prio_lock
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic        w  = bus_req.wr & clk_en;
	wire logic        r  = bus_req.rd & clk_en;
	wire logic [3:0]  a  = bus_req.addr;
	wire logic [15:0] d  = bus_req.wdata;
	wire logic        hi = cpu_prio_level > 4'h7;
	chk_var_bit: assert property ($past(w && a == 4'h0, 2) && $past(clk_en)
		|-> var_latency == $past(d[15], 2)) else $error("var");
	chk_flag_level: assert property ((clk_en && $stable(hi))[*3]
		|-> user_int_disable == hi) else $error("flag");
	chk_prio_top: assert property ((clk_en && $stable(hi))[*3]
		|-> cpu_priority[3] == hi) else $error("top");
	chk_lock_bit: assert property ($past(w && a == 4'h1, 2) && $past(clk_en)
		|-> lower_prio_lock == $past(d[15], 2)) else $error("lock");
	chk_low_write: assert property ($past(w && a == 4'h2, 2) && $past(clk_en)
		&& !$past(lower_prio_lock) |-> cpu_priority[2:0] == $past(d[7:5], 2)) else $error("low");
	chk_low_held: assert property ($past(w && a == 4'h2, 2) && $past(lower_prio_lock)
		|-> $stable(cpu_priority[2:0])) else $error("held");
	chk_core_gap: assert property ($past(r && a == 4'h0) |-> !rdata[14]) else $error("gap");
	chk_map_hole: assert property ($past(r && a > 4'h2) |-> rdata == 16'h0000) else $error("hole");
endmodule // ccr_regs_chk
bind ccr_regs ccr_regs_chk u_chk
(
	.core_clk         (core_clk),
	.nrst             (nrst),
	.clk_en           (clk_en),
	.bus_req          (bus_req),
	.rdata            (rdata),
	.cpu_prio_level   (cpu_prio_level),
	.cpu_priority     (cpu_priority),
	.var_latency      (var_latency),
	.user_int_disable (user_int_disable),
	.lower_prio_lock  (lower_prio_lock)
);

/* tb/test_ccr_regs.sv */
// bench for ccr_regs over its register port
// assumes the bound checker watches alongside
module test_ccr_regs
	import ccr_pkg::*;
;
	timeunit 1ns / 1ps;
	logic        core_clk = 0, nrst = 0, clk_en = 1;
	ccr_req_type bus_req = '0;
	logic [3:0]  cpu_prio_level = 4'h0, cpu_priority;
	logic [15:0] rdata;
	logic        var_latency, user_int_disable, lower_prio_lock;
	int          mismatches = 0, samples_checked = 0;
	ccr_regs dut
	(
		.core_clk         (core_clk),
		.nrst             (nrst),
		.clk_en           (clk_en),
		.bus_req          (bus_req),
		.rdata            (rdata),
		.cpu_prio_level   (cpu_prio_level),
		.var_latency      (var_latency),
		.cpu_priority     (cpu_priority),
		.user_int_disable (user_int_disable),
		.lower_prio_lock  (lower_prio_lock)
	);
	initial forever #4 core_clk = ~core_clk;
	task automatic stop_test;
		$display("%0d checked, %0d mismatches", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, s);
		samples_checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_bit(input string n, input logic e, s);
		samples_checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", n, e, s);
		end
	endtask
	// read data only stands in the cycle after the strobe; writes expect zero there
	task automatic bus(input logic [3:0] a, input logic [15:0] d, e, input logic w);
		@(posedge core_clk) bus_req <= '{a, d, w, !w};
		@(posedge core_clk) bus_req <= '0;
		@(negedge core_clk) cmp("rdata", e, rdata);
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		bus(4'h0, 16'h0000, 16'h0020, 1'b0);
		bus(4'h1, 16'h0000, 16'h0000, 1'b0);
		bus(4'h2, 16'h0000, 16'h0000, 1'b0);
		cmp_bit("var_latency", 1'b0, var_latency);
		cmp_bit("user_int_disable", 1'b0, user_int_disable);
		cmp_bit("lower_prio_lock", 1'b0, lower_prio_lock);
		cmp("cpu_priority", 16'h0000, {12'h000, cpu_priority});
		$display("reset test done");
		bus(4'h0, 16'hffff, 16'h0000, 1'b1);
		bus(4'h0, 16'h0000, 16'hb8f3, 1'b0);
		cmp_bit("var_latency", 1'b1, var_latency);
		bus(4'h1, 16'hffff, 16'h0000, 1'b1);
		bus(4'h1, 16'h0000, 16'hfffe, 1'b0);
		cmp_bit("lower_prio_lock", 1'b1, lower_prio_lock);
		$display("write mask test done");
		bus(4'h2, 16'h00e0, 16'h0000, 1'b1);
		bus(4'h2, 16'h0000, 16'h0000, 1'b0);
		bus(4'h1, 16'h0000, 16'h0000, 1'b1);
		bus(4'h2, 16'h00a0, 16'h0000, 1'b1);
		bus(4'h2, 16'h0000, 16'h00a0, 1'b0);
		cmp_bit("lower_prio_lock", 1'b0, lower_prio_lock);
		cmp("cpu_priority", 16'h0005, {12'h000, cpu_priority});
		bus(4'hf, 16'h0000, 16'h0000, 1'b0);
		$display("lock test done");
		// a frozen block must neither take the write nor answer it
		@(posedge core_clk) clk_en <= 1'b0;
		bus(4'h0, 16'h0000, 16'h0000, 1'b1);
		@(posedge core_clk) clk_en <= 1'b1;
		bus(4'h0, 16'h0000, 16'hb8f3, 1'b0);
		cmp_bit("var_latency", 1'b1, var_latency);
		bus(4'h0, 16'h0000, 16'h0000, 1'b1);
		bus(4'h0, 16'h0000, 16'h0000, 1'b0);
		cmp_bit("var_latency", 1'b0, var_latency);
		$display("clock enable test done");
		@(posedge core_clk) cpu_prio_level <= 4'h9;
		repeat (3) @(posedge core_clk);
		bus(4'h0, 16'h0000, 16'h0008, 1'b0);
		cmp("cpu_priority", 16'h000d, {12'h000, cpu_priority});
		cmp_bit("user_int_disable", 1'b1, user_int_disable);
		@(posedge core_clk) cpu_prio_level <= 4'h7;
		repeat (3) @(posedge core_clk);
		bus(4'h0, 16'h0000, 16'h0000, 1'b0);
		cmp("cpu_priority", 16'h0005, {12'h000, cpu_priority});
		cmp_bit("user_int_disable", 1'b0, user_int_disable);
		$display("priority test done");
		stop_test();
	end
endmodule // test_ccr_regs
